/* File: rtl/sdpc_fbdiv.sv */
// sdpc_fbdiv: divides encoder steps into a quadrature pair plus index
// assumes up and down steps are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module sdpc_fbdiv (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // encoder steps and index
  input  wire logic        up_i,
  input  wire logic        dn_i,
  input  wire logic        idx_i,
  input  wire logic [15:0] ratio_i,
  // divided phases
  output logic             a_o,
  output logic             b_o,
  output logic             c_o
);

  logic [15:0] acc_r;
  logic [1:0]  ph_r;
  logic        step;
  logic        wrap;

  // ratio 0 behaves as 1; up and down together cancel
  assign step = up_i ^ dn_i;
  assign wrap = (acc_r + 16'h1) >= ratio_i;

  // step accumulator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_r <= 16'h0;
    end else if (step) begin
      acc_r <= wrap ? 16'h0 : acc_r + 16'h1;
    end
  end

  // phase counter, up means phase a leads
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ph_r <= 2'h0;
    end else if (step && wrap) begin
      ph_r <= up_i ? ph_r + 2'h1 : ph_r - 2'h1;
    end
  end

  // registered phases; gray order 00,10,11,01 on {a,b}
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_o <= 1'b0;
      b_o <= 1'b0;
      c_o <= 1'b0;
    end else begin
      a_o <= ph_r[1] ^ ph_r[0];
      b_o <= ph_r[1];
      c_o <= idx_i;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/sdpc_pkg.sv */
// sdpc_pkg: constants and types of the servo discrete io and pulse block
// assumes one 100 MHz system clock; no bus, config arrives on plain ports
package sdpc_pkg;

  // system clock
  localparam int CLK_HZ = 100_000_000;

  // speed measuring window, time in microseconds and in cycles
  localparam int SPD_WIN_US = 1000;
  localparam int SPD_WIN_CYC = (CLK_HZ / 1_000_000) * SPD_WIN_US;

  // widths
  localparam int ERR_W = 24;
  localparam int SPD_W = 16;
  localparam int N_TERM = 6;
  localparam int MAP_SEL_W = 3;
  localparam int N_STAT = 4;
  localparam int OSEL_W = 2;

  // reset values of configuration registers
  localparam logic [15:0] BAND_RST = 16'h000a;
  // input functions 0..2: enable, multifunction, fwd limit on terms 0..2
  localparam logic [8:0] IN_MAP1_RST = {3'h2, 3'h1, 3'h0};
  // input functions 3..5: rev limit, fault clear, dev reset on terms 3..5
  localparam logic [8:0] IN_MAP2_RST = {3'h5, 3'h4, 3'h3};
  // output terms 0..3 carry status bits 0..3
  localparam logic [7:0] OUT_MAP_RST = {2'h3, 2'h2, 2'h1, 2'h0};

  // multifunction input choices
  typedef enum logic [4:0] {
    MF_PSW    = 5'h01,
    MF_DIR    = 5'h02,
    MF_MODE   = 5'h04,
    MF_ZCLAMP = 5'h08,
    MF_PINH   = 5'h10
  } sdpc_mf_t;

  // pulse reference formats
  typedef enum logic [2:0] {
    FMT_SIGN  = 3'h1,
    FMT_CCWCW = 3'h2,
    FMT_QUAD  = 3'h4
  } sdpc_fmt_t;

  // control methods
  typedef enum logic [1:0] {
    MODE_POS = 2'h1,
    MODE_SPD = 2'h2
  } sdpc_mode_t;

  // input functions after terminal mapping, index order 0..5 from lsb
  typedef struct packed {
    logic dclr;
    logic fclr;
    logic rev_ok;
    logic fwd_ok;
    logic mf;
    logic srv_en;
  } sdpc_cmd_t;

  // status outputs, index order 0..3 from lsb
  typedef struct packed {
    logic inpos;
    logic ready;
    logic fault_n;
    logic rot;
  } sdpc_stat_t;

endpackage

/* File: rtl/sdpc_sync.sv */
// sdpc_sync: three flip-flop synchroniser with agreement filter
// assumes asynchronous inputs; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sdpc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // asynchronous in, stable out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1 is only read by s2, never by logic
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: take the level once two stages agree, rejects metastable blips
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/sdpc_top.sv */
// sdpc_top: discrete io and pulse reference logic of a servo drive
// assumes pins are asynchronous; power and fault conditions come on this clock
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] rotation detect on when measured speed magnitude exceeds threshold
// [R2] fault output goes low on any abnormal condition, high when healthy
// [R3] ready only with both powers, no fault and no overtravel
// [R4] in-position on once deviation magnitude is within the band
// [R5] band defaults to ten pulses and is reloadable by configuration
// [R6] servo enable powers the motor; without it the motor is off
// [R7] multifunction input has one function picked by configuration
// [R8] proportional switch turns speed loop from PI to P only
// [R9] direction switch reverses rotation when internal speed selection used
// [R10] mode switch picks between the two configured control methods
// [R11] zero clamp forces commanded speed to zero in speed control
// [R12] pulse inhibit stops command pulse acceptance in position control
// [R13] a limit input going off blocks motion toward that direction
// [R14] host pulses come as sign+pulse, ccw/cw or quadrature; decode setting
// [R15] fault clear releases the latched fault state
// [R16] deviation reset zeroes the deviation counter in position control
// [R17] divided encoder feedback on phases a, b and index c
// [R18] three map parameters reassign terminals, factory defaults after reset
// [R19] all pins synchronised first; quadrature counts by leading phase
// [R20] deviation reset and inhibit win over pulse counting
module sdpc_top #(
  parameter int SPD_WIN = sdpc_pkg::SPD_WIN_CYC
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // discrete input terminals and pulse pins
  input  wire logic [5:0]             term_in_i,
  input  wire logic                   cmd_pulse_in_i,
  input  wire logic                   cmd_sign_in_i,
  input  wire logic                   enc_a_i,
  input  wire logic                   enc_b_i,
  input  wire logic                   enc_z_i,
  // drive state on this clock
  input  wire logic                   ctrl_pwr_ok_i,
  input  wire logic                   main_pwr_ok_i,
  input  wire logic [3:0]             fault_cond_i,
  input  wire logic signed [15:0]     speed_cmd_i,
  // configuration
  input  wire sdpc_pkg::sdpc_mf_t     mf_sel_i,
  input  wire sdpc_pkg::sdpc_fmt_t    fmt_sel_i,
  input  wire sdpc_pkg::sdpc_mode_t   mode_a_i,
  input  wire sdpc_pkg::sdpc_mode_t   mode_b_i,
  input  wire logic                   int_speed_sel_i,
  input  wire logic [15:0]            rotation_detect_out_level_i,
  input  wire logic [15:0]            fb_div_ratio_i,
  input  wire logic                   cfg_load_i,
  input  wire logic [15:0]            in_position_band_param_i,
  input  wire logic [8:0]             input_map_param_1_i,
  input  wire logic [8:0]             input_map_param_2_i,
  input  wire logic [7:0]             output_map_param_i,
  // status and drive commands
  output sdpc_pkg::sdpc_stat_t        stat_o,
  output logic [3:0]                  term_out_o,
  output logic                        motor_power_o,
  output logic                        p_only_o,
  output logic                        dir_rev_o,
  output sdpc_pkg::sdpc_mode_t        mode_o,
  output logic signed [15:0]          speed_cmd_o,
  output logic signed [23:0]          deviation_o,
  // divided feedback
  output logic                        feedback_phase_a_out_o,
  output logic                        feedback_phase_b_out_o,
  output logic                        feedback_index_out_o
);

  localparam int EW = sdpc_pkg::ERR_W;
  localparam int SW = sdpc_pkg::SPD_W;

  logic [5:0]           term_s;
  logic [4:0]           pin_s;
  logic [4:0]           pin_q_r;
  sdpc_pkg::sdpc_cmd_t  cmd;
  logic [8:0]           map1_r;
  logic [8:0]           map2_r;
  logic [7:0]           omap_r;
  logic [15:0]          band_r;
  logic                 fclr_q_r;
  logic                 fault_r;
  logic                 r_up;
  logic                 r_dn;
  logic                 fb_up;
  logic                 fb_dn;
  logic                 pos_mode;
  logic                 pinh;
  logic                 zclamp;
  logic                 dir_sw;
  logic                 clr_go;
  logic                 ready;
  logic                 pwr;
  logic [EW-1:0]        delta;
  logic signed [EW-1:0] err_r;
  logic [EW-1:0]        err_abs;
  logic [31:0]          win_r;
  logic signed [SW-1:0] spd_cnt_r;
  logic signed [SW-1:0] spd_r;
  logic [SW-1:0]        spd_abs;
  logic signed [15:0]   spd_nxt;
  sdpc_pkg::sdpc_mode_t mode_nxt;
  sdpc_pkg::sdpc_stat_t stat_nxt;

  // quadrature step: {up, dn}; up when a leads b
  function automatic logic [1:0] quad_step(input logic [1:0] p,
                                           input logic [1:0] c);
    logic mv;
    mv = (p[1] ^ c[1]) ^ (p[0] ^ c[0]);
    quad_step = {mv & (p[1] ^ c[0]), mv & ~(p[1] ^ c[0])};
  endfunction

  // every pin through three flops before any edge logic
  sdpc_sync #(.W(6)) u_term_sync ( // [R19]
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (term_in_i),
    .q_o     (term_s)
  );

  sdpc_sync #(.W(5)) u_pin_sync ( // [R19]
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({enc_z_i, enc_b_i, enc_a_i, cmd_sign_in_i, cmd_pulse_in_i}),
    .q_o     (pin_s)
  );

  // map and band registers; defaults hold until software loads new ones
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      map1_r <= sdpc_pkg::IN_MAP1_RST; // [R18]
      map2_r <= sdpc_pkg::IN_MAP2_RST;
      omap_r <= sdpc_pkg::OUT_MAP_RST;
      band_r <= sdpc_pkg::BAND_RST; // [R5]
    end else if (cfg_load_i) begin
      map1_r <= input_map_param_1_i;
      map2_r <= input_map_param_2_i;
      omap_r <= output_map_param_i;
      band_r <= in_position_band_param_i;
    end
  end

  // terminal to function routing; an unused selector reads zero
  always_comb begin
    logic [17:0] m;
    logic [2:0]  s;
    s = 3'h0;
    m = {map2_r, map1_r};
    cmd = '0;
    for (int k = 0; k < sdpc_pkg::N_TERM; k++) begin
      s = m[k*sdpc_pkg::MAP_SEL_W +: sdpc_pkg::MAP_SEL_W];
      cmd[k] = (s < 3'h6) ? term_s[s] : 1'b0; // [R18]
    end
  end

  // previous pin levels for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_q_r <= 5'h0;
      fclr_q_r <= 1'b0;
    end else begin
      pin_q_r <= pin_s;
      fclr_q_r <= cmd.fclr;
    end
  end

  // multifunction decode, only the configured function acts
  always_comb begin
    mode_nxt = (mf_sel_i == sdpc_pkg::MF_MODE && cmd.mf) ?
               mode_b_i : mode_a_i; // [R7] [R10]
    pos_mode = mode_nxt == sdpc_pkg::MODE_POS;
    pinh   = mf_sel_i == sdpc_pkg::MF_PINH && cmd.mf && pos_mode; // [R12]
    zclamp = mf_sel_i == sdpc_pkg::MF_ZCLAMP && cmd.mf && !pos_mode; // [R11]
    dir_sw = mf_sel_i == sdpc_pkg::MF_DIR && cmd.mf && int_speed_sel_i; // [R9]
    clr_go = cmd.dclr && pos_mode; // [R16]
  end

  // reference pulse decode per format, then travel and inhibit gating
  always_comb begin
    logic [1:0] q;
    logic       pr;
    logic       sr;
    logic       u;
    logic       d;
    u  = 1'b0;
    d  = 1'b0;
    q  = quad_step(pin_q_r[1:0], pin_s[1:0]);
    pr = pin_s[0] & ~pin_q_r[0];
    sr = pin_s[1] & ~pin_q_r[1];
    case (fmt_sel_i) // [R14]
      sdpc_pkg::FMT_SIGN: begin
        u = pr & ~pin_s[1];
        d = pr & pin_s[1];
      end
      sdpc_pkg::FMT_CCWCW: begin
        u = pr;
        d = sr;
      end
      sdpc_pkg::FMT_QUAD: begin
        u = q[1]; // [R19]
        d = q[0];
      end
      default: begin
        u = 1'b0;
        d = 1'b0;
      end
    endcase
    // inhibit drops pulses, limits block the prohibited direction
    r_up = u & ~pinh & cmd.fwd_ok; // [R12] [R13]
    r_dn = d & ~pinh & cmd.rev_ok; // [R13]
  end

  // encoder feedback steps
  assign {fb_up, fb_dn} = quad_step(pin_q_r[3:2], pin_s[3:2]); // [R19]

  // deviation: reference minus feedback; clear beats counting
  assign delta = EW'(r_up) - EW'(r_dn) - EW'(fb_up) + EW'(fb_dn);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      err_r <= '0;
    end else if (clr_go) begin
      err_r <= '0; // [R16] [R20]
    end else begin
      err_r <= err_r + $signed(delta);
    end
  end

  assign err_abs = err_r[EW-1] ? EW'(-err_r) : EW'(err_r);

  // speed window: signed feedback steps per window
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      win_r <= 32'h0;
      spd_cnt_r <= '0;
      spd_r <= '0;
    end else if (win_r == 32'(SPD_WIN - 1)) begin
      win_r <= 32'h0;
      spd_r <= spd_cnt_r;
      spd_cnt_r <= '0;
    end else begin
      win_r <= win_r + 32'h1;
      spd_cnt_r <= spd_cnt_r + SW'(fb_up) - SW'(fb_dn);
    end
  end

  assign spd_abs = spd_r[SW-1] ? SW'(-spd_r) : SW'(spd_r);

  // fault latch: a new condition wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fault_r <= 1'b0;
    end else if (|fault_cond_i) begin
      fault_r <= 1'b1;
    end else if (cmd.fclr && !fclr_q_r) begin
      fault_r <= 1'b0; // [R15]
    end
  end

  assign ready = ctrl_pwr_ok_i && main_pwr_ok_i && !fault_r &&
                 cmd.fwd_ok && cmd.rev_ok; // [R3]
  assign pwr = cmd.srv_en && ctrl_pwr_ok_i && main_pwr_ok_i &&
               !fault_r; // [R6]

  // status vector
  always_comb begin
    stat_nxt.rot     = spd_abs > rotation_detect_out_level_i; // [R1]
    stat_nxt.fault_n = !fault_r; // [R2]
    stat_nxt.ready   = ready;
    stat_nxt.inpos   = err_abs <= EW'(band_r); // [R4]
  end

  // speed command; zero when unpowered, clamped or toward a limit
  always_comb begin
    spd_nxt = dir_sw ? -speed_cmd_i : speed_cmd_i; // [R9]
    if (!pwr || zclamp) begin
      spd_nxt = 16'sh0; // [R11]
    end else if ((!cmd.fwd_ok && spd_nxt > 0) ||
                 (!cmd.rev_ok && spd_nxt < 0)) begin
      spd_nxt = 16'sh0; // [R13]
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      stat_o <= '0;
      term_out_o <= 4'h0;
      motor_power_o <= 1'b0;
      p_only_o <= 1'b0;
      dir_rev_o <= 1'b0;
      mode_o <= sdpc_pkg::MODE_POS;
      speed_cmd_o <= 16'sh0;
      deviation_o <= '0;
    end else begin
      stat_o <= stat_nxt;
      for (int j = 0; j < sdpc_pkg::N_STAT; j++) begin
        term_out_o[j] <= stat_nxt[omap_r[j*2 +: 2]]; // [R18]
      end
      motor_power_o <= pwr; // [R6]
      p_only_o <= mf_sel_i == sdpc_pkg::MF_PSW && cmd.mf; // [R8]
      dir_rev_o <= dir_sw;
      mode_o <= mode_nxt;
      speed_cmd_o <= spd_nxt;
      deviation_o <= err_r;
    end
  end

  // divided encoder feedback
  sdpc_fbdiv u_fbdiv ( // [R17]
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .up_i    (fb_up),
    .dn_i    (fb_dn),
    .idx_i   (pin_s[4]),
    .ratio_i (fb_div_ratio_i),
    .a_o     (feedback_phase_a_out_o),
    .b_o     (feedback_phase_b_out_o),
    .c_o     (feedback_index_out_o)
  );

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_clear;
    clr_go ##1 (err_r == 0);
  endsequence

  sequence s_fault_clear;
    fault_r ##1 (cmd.fclr && !fclr_q_r && fault_cond_i == 4'h0);
  endsequence

  AST_FAULT_OUT: assert property ((|fault_cond_i) |=> ##1 !stat_o.fault_n) // [R2]
    else $error("fault output not low after condition");
  AST_READY: assert property (!cmd.fwd_ok || fault_r |=> !stat_o.ready) // [R3]
    else $error("ready with overtravel or fault");
  AST_CLEAR_INPOS: assert property (s_clear |=> stat_o.inpos) // [R4]
    else $error("deviation reset did not give in-position");
  AST_BAND_RST: assert property ($rose(rst_n_i) |-> band_r == 16'h000a) // [R5]
    else $error("band not ten after reset");
  AST_MOTOR_OFF: assert property (!cmd.srv_en |=> !motor_power_o) // [R6]
    else $error("motor powered without enable");
  AST_PSW: assert property (mf_sel_i == sdpc_pkg::MF_PSW && cmd.mf // [R8]
    |=> p_only_o && !dir_rev_o)
    else $error("proportional switch not applied");
  AST_ZCLAMP: assert property (zclamp |=> speed_cmd_o == 0) // [R11]
    else $error("zero clamp not applied");
  AST_INHIBIT: assert property (pinh && !clr_go && !fb_up && !fb_dn // [R12]
    |=> err_r == $past(err_r))
    else $error("pulse counted while inhibited");
  AST_OT_FWD: assert property (!cmd.fwd_ok |=> speed_cmd_o <= 0) // [R13]
    else $error("forward motion past limit");
  AST_FCLR: assert property (s_fault_clear |=> !fault_r ##1 stat_o.fault_n) // [R15]
    else $error("fault clear not honoured");
  AST_DEV_CLR: assert property (clr_go |=> err_r == 0 ##1 deviation_o == 0) // [R16]
    else $error("deviation not cleared");

endmodule
`default_nettype wire

/* File: test/sdpc_host.sv */
// sdpc_host: host controller model driving one pulse reference pair
// assumes the format input is settled before a step and held during it
`timescale 1ns/1ps
`default_nettype none
module sdpc_host (
  // clock and format
  input  wire logic                clk_i,
  input  wire sdpc_pkg::sdpc_fmt_t fmt_i,
  // pulse pins
  output logic                     pulse_o,
  output logic                     sign_o
);
  logic [1:0] q_r;

  // pins idle low, quadrature state 00
  initial begin
    pulse_o = 1'b0;
    sign_o  = 1'b0;
    q_r     = 2'h0;
  end

  // each level lasts 4 cycles, above the 2-cycle sync minimum
  task automatic hold();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // one reference step, dn high for reverse
  task automatic step(input logic dn);
    if (fmt_i == sdpc_pkg::FMT_QUAD) begin
      q_r     = dn ? q_r - 2'h1 : q_r + 2'h1;
      pulse_o = q_r[0] ^ q_r[1];
      sign_o  = q_r[1];
      hold();
    end else begin
      if (fmt_i == sdpc_pkg::FMT_CCWCW) begin
        if (dn) sign_o = 1'b1;
        else pulse_o = 1'b1;
      end else begin
        sign_o = dn;
        hold();
        pulse_o = 1'b1;
      end
      hold();
      pulse_o = 1'b0;
      sign_o  = 1'b0;
      hold();
    end
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// testbench: self-checking bench of the servo discrete io block
// assumes sdpc_pkg and sdpc_host are compiled first; speed window set to 50
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    sdpc_pkg::sdpc_mf_t   mf;
    logic                 on;
    sdpc_pkg::sdpc_mode_t md;
    logic                 po;
    logic                 dr;
    logic [15:0]          sp;
  } sdpc_row_t;

  logic                 ref_clk_i, rst_n_i, cp, mp, ld, enc_z, isp;
  logic                 pul, sgn, ea, eb, mpow, ponly, drev, fa, fb, fc;
  logic [5:0]           term;
  logic [3:0]           flt, tout;
  logic [15:0]          rotation_detect_out, band;
  logic [7:0]           omap;
  logic signed [15:0]   spd_out;
  logic signed [23:0]   dev;
  sdpc_pkg::sdpc_mf_t   mf;
  sdpc_pkg::sdpc_fmt_t  fmt;
  sdpc_pkg::sdpc_mode_t mode_a, mode_b, mode;
  sdpc_pkg::sdpc_stat_t stat;
  int                   error_cnt, total_checks;

  // speed 0064 in, speed mode unless mode switch picks position
  sdpc_row_t rows [9] = '{
    '{sdpc_pkg::MF_PSW, 1'b0, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0064},
    '{sdpc_pkg::MF_PSW, 1'b1, sdpc_pkg::MODE_SPD, 1'b1, 1'b0, 16'h0064},
    '{sdpc_pkg::MF_DIR, 1'b1, sdpc_pkg::MODE_SPD, 1'b0, 1'b1, 16'hff9c},
    '{sdpc_pkg::MF_DIR, 1'b0, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0064},
    '{sdpc_pkg::MF_MODE, 1'b1, sdpc_pkg::MODE_POS, 1'b0, 1'b0, 16'h0000},
    '{sdpc_pkg::MF_MODE, 1'b0, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0064},
    '{sdpc_pkg::MF_ZCLAMP, 1'b1, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0000},
    '{sdpc_pkg::MF_ZCLAMP, 1'b0, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0064},
    '{sdpc_pkg::MF_PINH, 1'b1, sdpc_pkg::MODE_SPD, 1'b0, 1'b0, 16'h0064}
  };
  sdpc_pkg::sdpc_fmt_t fmts [3] = '{sdpc_pkg::FMT_SIGN,
                                    sdpc_pkg::FMT_CCWCW, sdpc_pkg::FMT_QUAD};

  sdpc_top #(.SPD_WIN(50)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .term_in_i(term),
    .cmd_pulse_in_i(pul), .cmd_sign_in_i(sgn), .enc_a_i(ea), .enc_b_i(eb),
    .enc_z_i(enc_z), .ctrl_pwr_ok_i(cp), .main_pwr_ok_i(mp),
    .fault_cond_i(flt), .speed_cmd_i(16'sh0064), .mf_sel_i(mf),
    .fmt_sel_i(fmt), .mode_a_i(mode_a), .mode_b_i(mode_b),
    .int_speed_sel_i(isp), .rotation_detect_out_level_i(rotation_detect_out), .fb_div_ratio_i(16'h0001),
    .cfg_load_i(ld), .in_position_band_param_i(band),
    .input_map_param_1_i(sdpc_pkg::IN_MAP1_RST),
    .input_map_param_2_i(sdpc_pkg::IN_MAP2_RST),
    .output_map_param_i(omap), .stat_o(stat), .term_out_o(tout),
    .motor_power_o(mpow), .p_only_o(ponly), .dir_rev_o(drev),
    .mode_o(mode), .speed_cmd_o(spd_out), .deviation_o(dev),
    .feedback_phase_a_out_o(fa), .feedback_phase_b_out_o(fb),
    .feedback_index_out_o(fc)
  );
  // command pins and encoder phases come from two host models
  sdpc_host i_host (.clk_i(ref_clk_i), .fmt_i(fmt), .pulse_o(pul),
                    .sign_o(sgn));
  sdpc_host i_enc (.clk_i(ref_clk_i), .fmt_i(sdpc_pkg::FMT_QUAD),
                   .pulse_o(ea), .sign_o(eb));

  // free-running 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // returns 1 ns after an edge so inputs never race the sampling edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic steps(input int n, input logic dn);
    repeat (n) i_host.step(dn);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n_i = 1'b0; term = 6'h00; cp = 1'b1; mp = 1'b1; flt = 4'h0;
    ld = 1'b0; enc_z = 1'b0; rotation_detect_out = 16'h0002; band = 16'h000a; isp = 1'b1;
    omap = sdpc_pkg::OUT_MAP_RST; mf = sdpc_pkg::MF_PSW;
    fmt = sdpc_pkg::FMT_SIGN; mode_a = sdpc_pkg::MODE_SPD;
    mode_b = sdpc_pkg::MODE_POS; error_cnt = 0; total_checks = 0;
    wt(8);
    rst_n_i = 1'b1;
    chk(stat, 4'h0);
    chk(mode, sdpc_pkg::MODE_POS);
    // enable on so the speed column is not forced to zero by power gating
    term = 6'h0d;
    wt(8);
    // table of multifunction cases, one function live at a time
    foreach (rows[i]) begin
      mf = rows[i].mf;
      term[1] = rows[i].on;
      wt(8);
      chk(ponly, rows[i].po);
      chk(drev, rows[i].dr);
      chk(mode, rows[i].md);
      if (rows[i].md == sdpc_pkg::MODE_SPD)
        chk({8'h0, spd_out}, {8'h0, rows[i].sp});
    end
    // direction switch is void without internal speed selection
    isp = 1'b0; mf = sdpc_pkg::MF_DIR; term[1] = 1'b1;
    wt(8);
    chk(drev, 1'b0);
    chk({8'h0, spd_out}, 24'h000064);
    // ready and motor power against power, limits and faults
    mf = sdpc_pkg::MF_PINH; mode_a = sdpc_pkg::MODE_POS; term = 6'h0d;
    wt(8);
    chk(stat.ready, 1'b1);
    chk(stat.fault_n, 1'b1);
    chk(mpow, 1'b1);
    cp = 1'b0;
    wt(3);
    chk(stat.ready, 1'b0);
    cp = 1'b1; mp = 1'b0;
    wt(3);
    chk(mpow, 1'b0);
    mp = 1'b1; term[2] = 1'b0;
    wt(8);
    chk(stat.ready, 1'b0);
    chk(mpow, 1'b1);
    term[2] = 1'b1; flt = 4'h2;
    wt(1);
    flt = 4'h0;
    wt(2);
    chk(stat.fault_n, 1'b0);
    wt(8);
    chk(mpow, 1'b0);
    term[4] = 1'b1;
    wt(8);
    chk(stat.fault_n, 1'b1);
    term[4] = 1'b0;
    // every pulse format: three up, one down
    foreach (fmts[k]) begin
      fmt = fmts[k]; term[5] = 1'b1;
      wt(8);
      chk(dev, 24'h0);
      term[5] = 1'b0;
      wt(2);
      steps(3, 1'b0);
      steps(1, 1'b1);
      wt(8);
      chk(dev, 24'h2);
      chk(stat.inpos, 1'b1);
    end
    // band edge at ten pulses
    steps(9, 1'b0);
    wt(8);
    chk(stat.inpos, 1'b0);
    steps(1, 1'b1);
    wt(8);
    chk(stat.inpos, 1'b1);
    term[1] = 1'b1;
    wt(8);
    steps(2, 1'b0);
    wt(8);
    chk(dev, 24'ha);
    term[1] = 1'b0; term[2] = 1'b0;
    wt(8);
    steps(2, 1'b0);
    steps(1, 1'b1);
    wt(8);
    chk(dev, 24'h9);
    term[2] = 1'b1; term[5] = 1'b1;
    steps(2, 1'b0);
    wt(8);
    chk(dev, 24'h0);
    // band of one and reversed output map; limitation: input maps stay put
    term[5] = 1'b0; band = 16'h0001; omap = 8'h1b; ld = 1'b1;
    wt(1);
    ld = 1'b0;
    steps(2, 1'b0);
    wt(8);
    chk(stat.inpos, 1'b0);
    chk(tout, 4'b0110);
    // encoder feedback, then speed detect over the 50-cycle window
    i_enc.step(1'b0);
    wt(8);
    chk({fa, fb}, 2'b10);
    chk(dev, 24'h1);
    repeat (25) i_enc.step(1'b0);
    chk(stat.rot, 1'b1);
    wt(120);
    chk(stat.rot, 1'b0);
    enc_z = 1'b1;
    for (int n = 0; n < 12 && fc !== 1'b1; n++) wt(1);
    chk(fc, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
